// ### common/eps_defs.vh
`ifndef EPS_DEFS_VH
`define EPS_DEFS_VH

// register byte offsets
`define EPS_OFF_CTRL     8'h00
`define EPS_OFF_UPR      8'h04
`define EPS_OFF_RANGE    8'h08
`define EPS_OFF_PRESET   8'h0c
`define EPS_OFF_OFFSET   8'h10
`define EPS_OFF_POS      8'h14
`define EPS_OFF_VEL      8'h18
`define EPS_OFF_STATUS   8'h1c

// control register field positions
`define EPS_CTRL_DIR_CCW 0
`define EPS_CTRL_SCALE   1
`define EPS_CTRL_EXT     2
`define EPS_CTRL_RPM     3

// status register field positions
`define EPS_STAT_VALID   0
`define EPS_STAT_SCALED  1
`define EPS_STAT_PEND    2

// reset values and limits
`define EPS_CTRL_RST     4'h4
`define EPS_UPR_RST      17'h10000
`define EPS_UPR_MAX      32'h00010000
`define EPS_UPR_MIN_ST   32'h00000002
`define EPS_UPR_MIN_MT   32'h00000001
`define EPS_RANGE_MIN    32'h00000002

// axi responses
`define EPS_RESP_OKAY    2'h0
`define EPS_RESP_SLVERR  2'h2

`endif

// ### verilog/eps_sync.v
// two-flop level synchroniser for the shaft sensor bus;
// the source must change only one bit at a time or be stable when read
module eps_sync #(
    parameter W = 30
) (
    // clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // data
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds only the second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// ### verilog/eps_modred.v
// restoring remainder unit: rem = dividend mod divisor, one bit per cycle
module eps_modred (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // request
    input  wire        start,
    input  wire [31:0] dividend,
    input  wire [31:0] divisor,
    // answer
    output wire        done,
    output wire [31:0] rem
);
    reg [31:0] dvd_q;
    reg [32:0] rem_q;
    reg [31:0] div_q;
    reg [5:0]  cnt_q;
    reg        busy_q;
    reg        done_q;

    wire [32:0] shifted = {rem_q[31:0], dvd_q[31]};
    wire        fits    = shifted >= {1'b0, div_q};

    // 32 shift-subtract steps; done pulses in the same cycle as the last step's result
    always @(posedge aclk) begin
        if (!aresetn) begin
            dvd_q  <= 32'h0;
            rem_q  <= 33'h0;
            div_q  <= 32'h0;
            cnt_q  <= 6'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                dvd_q  <= dividend;
                div_q  <= divisor;
                rem_q  <= 33'h0;
                cnt_q  <= 6'h20;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                dvd_q <= {dvd_q[30:0], 1'b0};
                rem_q <= fits ? shifted - {1'b0, div_q} : shifted;
                cnt_q <= cnt_q - 6'h1;
                if (cnt_q == 6'h1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign done = done_q;
    assign rem  = rem_q[31:0];
endmodule

// ### verilog/eps_top.v
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "eps_defs.vh"

// How it works
// (R1) direction bit picks the counting rotation; reset counts up clockwise
// (R2) reversal reports maximum count minus the former position
// (R3) scaling off: native 16 bit per turn counts, scale settings ignored
// (R4) scaling on: position and velocity in units of the two settings
// (R5) scaling on scales velocity by units per turn, except in rpm format
// (R6) extended functions off forces scaling off and full native range
// (R7) units per turn accepts 2..65536 single-turn, 1..65536 multi-turn
// (R8) changing units per turn clears the stored position offset
// (R9) total range sets the wrap point and bounds position and preset
// (R10) total range accepts 2 up to the native count span
// (R11) changing total range clears the stored position offset
// (R12) total range is not limited by units per turn
// (R13) scaling off: available counts are 65536 times encodable turns
// (R14) scaling on: available counts are units per turn times encodable turns
// (R15) range below available counts wraps position to zero early
// (R16) integer quotient keeps absolute position across any unpowered rotation
// (R17) fractional quotient recovers only within half the span while unpowered
// (R18) range above units per turn needs range over units turns to wrap
// (R19) controller keeps position across reversal by read, flip, then preset
// (R20) preset legal range is 0 to active range minus one
// (R21) position is direction-applied scaled count plus offset, modulo range
module eps_top #(
    parameter TURN_BITS = 14,
    parameter NB        = 16 + TURN_BITS
) (
    // clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // axi4-lite write address
    input  wire          s_axi_awvalid,
    output wire          s_axi_awready,
    input  wire [7:0]    s_axi_awaddr,
    // axi4-lite write data
    input  wire          s_axi_wvalid,
    output wire          s_axi_wready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    // axi4-lite write response
    output wire          s_axi_bvalid,
    input  wire          s_axi_bready,
    output wire [1:0]    s_axi_bresp,
    // axi4-lite read address
    input  wire          s_axi_arvalid,
    output wire          s_axi_arready,
    input  wire [7:0]    s_axi_araddr,
    // axi4-lite read data
    output wire          s_axi_rvalid,
    input  wire          s_axi_rready,
    output wire [31:0]   s_axi_rdata,
    output wire [1:0]    s_axi_rresp,
    // shaft sensor, native counts, outside clock domain
    input  wire [NB-1:0] raw_count,
    // speed estimator, native counts per unit time, same clock
    input  wire [31:0]   vel_raw,
    // reported values
    output wire [31:0]   position,
    output wire          position_upd,
    output wire [31:0]   velocity
);
    localparam [31:0] RNG_NAT = 32'h1 << NB;
    localparam [31:0] UPR_MIN = (TURN_BITS == 0) ? `EPS_UPR_MIN_ST : `EPS_UPR_MIN_MT;
    localparam [2:0]  ST_IDLE = 3'b001;
    localparam [2:0]  ST_WAIT = 3'b010;
    localparam [2:0]  ST_POST = 3'b100;

    // configuration and state registers
    reg  [3:0]  ctrl_q;
    reg  [16:0] upr_q;
    reg  [31:0] range_q;
    reg  [31:0] preset_q;
    reg  [31:0] offset_q;
    reg         pend_q;
    reg  [31:0] pos_q;
    reg         upd_q;
    reg         valid_q;
    reg  [31:0] vel_q;
    reg  [2:0]  st_q;
    reg  [31:0] dvd_q;
    reg  [31:0] rng_q;
    reg         dirty_q;
    reg         start_q;
    // axi bookkeeping
    reg         aw_full_q;
    reg         w_full_q;
    reg  [7:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         bvalid_q;
    reg  [1:0]  bresp_q;
    reg         rvalid_q;
    reg  [31:0] rdata_q;
    reg  [1:0]  rresp_q;

    wire [NB-1:0] count_s;
    wire          div_done;
    wire [31:0]   div_rem;

    // multi-bit crossing; the sensor bus is gray or held while sampled
    eps_sync #(
        .W (NB)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (raw_count),
        .dout    (count_s)
    );

    // active scaling and range selection
    wire        scale_on = ctrl_q[`EPS_CTRL_SCALE] & ctrl_q[`EPS_CTRL_EXT]; // R3 R4 R6
    wire        ccw      = ctrl_q[`EPS_CTRL_DIR_CCW]; // R1
    wire [31:0] act_rng  = scale_on ? range_q : RNG_NAT; // R6 R9 R13
    wire [31:0] avail    = scale_on ? ({15'h0, upr_q} << TURN_BITS)        // R14
                                    : RNG_NAT;                              // R13

    // scaled count: native count times units per turn over 65536
    wire [NB+16:0] prod   = count_s * upr_q; // R4
    wire [31:0]    scaled = scale_on ? {{(15-TURN_BITS){1'b0}}, prod[NB+16:16]}
                                     : {{(32-NB){1'b0}}, count_s};          // R3
    // reversed sense counts down from the available maximum
    wire [31:0]    dir_val = ccw ? avail - scaled : scaled; // R2

    // axi write path
    wire do_write = aw_full_q & w_full_q & ~bvalid_q;
    assign s_axi_awready = ~aw_full_q & ~bvalid_q;
    assign s_axi_wready  = ~w_full_q & ~bvalid_q;

    // byte-lane merge of the held write data onto a register's old value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    reg [31:0] old_val;
    always @* begin
        case (awaddr_q)
            `EPS_OFF_CTRL:   old_val = {28'h0, ctrl_q};
            `EPS_OFF_UPR:    old_val = {15'h0, upr_q};
            `EPS_OFF_RANGE:  old_val = range_q;
            `EPS_OFF_PRESET: old_val = preset_q;
            `EPS_OFF_OFFSET: old_val = offset_q;
            default:         old_val = 32'h0;
        endcase
    end

    wire [31:0] wd       = merge(old_val, wdata_q, wstrb_q);
    wire        wr_ctrl  = do_write && awaddr_q == `EPS_OFF_CTRL;
    wire        wr_upr   = do_write && awaddr_q == `EPS_OFF_UPR;
    wire        wr_rng   = do_write && awaddr_q == `EPS_OFF_RANGE;
    wire        wr_pre   = do_write && awaddr_q == `EPS_OFF_PRESET;
    wire        wr_off   = do_write && awaddr_q == `EPS_OFF_OFFSET;
    wire        upr_ok   = wd >= UPR_MIN && wd <= `EPS_UPR_MAX; // R7
    wire        rng_ok   = wd >= `EPS_RANGE_MIN && wd <= RNG_NAT; // R10 R12
    wire        pre_ok   = wd < act_rng; // R20
    wire        known    = wr_ctrl | wr_upr | wr_rng | wr_pre | wr_off;
    wire        wr_err   = ~known | (wr_upr & ~upr_ok) | (wr_rng & ~rng_ok)
                         | ((wr_pre | wr_off) & ~pre_ok);
    wire        upr_chg  = wr_upr & upr_ok & (wd[16:0] != upr_q);          // R8
    wire        rng_chg  = wr_rng & rng_ok & (wd != range_q);              // R11

    // write address and data are latched independently, then applied together
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awaddr_q  <= 8'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `EPS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_err ? `EPS_RESP_SLVERR : `EPS_RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // configuration registers; out-of-range values are refused and kept
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q   <= `EPS_CTRL_RST;
            upr_q    <= `EPS_UPR_RST;
            range_q  <= RNG_NAT;
            preset_q <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wd[3:0]; // R1
            end
            if (wr_upr && upr_ok) begin
                upr_q <= wd[16:0]; // R7
            end
            if (wr_rng && rng_ok) begin
                range_q <= wd; // R9 R10
            end
            if (wr_pre && pre_ok) begin
                preset_q <= wd; // R20
            end
        end
    end

    // preset offset: reduce (preset - r) into the active range
    wire [31:0] r1       = div_rem;
    wire [31:0] pre_raw  = preset_q + rng_q - r1;
    wire [31:0] pre_off  = (pre_raw >= rng_q) ? pre_raw - rng_q : pre_raw;
    wire [31:0] off_use  = pend_q ? pre_off : offset_q;
    wire [31:0] pos_raw  = r1 + off_use;
    wire [31:0] pos_mod  = (pos_raw >= rng_q) ? pos_raw - rng_q : pos_raw; // R15 R21

    // stored offset; a units per turn or total range change discards the position reference
    always @(posedge aclk) begin
        if (!aresetn) begin
            offset_q <= 32'h0;
            pend_q   <= 1'b0;
        end else begin
            if (upr_chg || rng_chg) begin
                offset_q <= 32'h0; // R8 R11
            end else if (wr_off && pre_ok) begin
                offset_q <= wd; // R16 R17
            end else if (st_q == ST_POST && pend_q) begin
                offset_q <= pre_off; // R20
            end
            // a new preset arriving while one is applied stays pending
            if (wr_pre && pre_ok) begin
                pend_q <= 1'b1;
            end else if (st_q == ST_POST && !do_write) begin
                pend_q <= 1'b0;
            end
        end
    end

    // position loop: sample, reduce by range, add offset, publish
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_q    <= ST_IDLE;
            dvd_q   <= 32'h0;
            rng_q   <= RNG_NAT;
            dirty_q <= 1'b0;
            start_q <= 1'b0;
            pos_q   <= 32'h0;
            upd_q   <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            upd_q   <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    dvd_q   <= dir_val; // R2 R21
                    rng_q   <= act_rng; // R9
                    start_q <= 1'b1;
                    dirty_q <= do_write;
                    st_q    <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (do_write) begin
                        dirty_q <= 1'b1;
                    end
                    if (div_done) begin
                        // a result taken under old settings is thrown away
                        st_q <= (dirty_q || do_write) ? ST_IDLE : ST_POST;
                    end
                end
                ST_POST: begin
                    if (!do_write) begin
                        pos_q   <= pos_mod; // R15 R18 R21
                        upd_q   <= 1'b1;
                        valid_q <= 1'b1;
                    end
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    eps_modred u_modred (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (start_q),
        .dividend (dvd_q),
        .divisor  (rng_q),
        .done     (div_done),
        .rem      (div_rem)
    );

    // velocity: scaled by units per turn when scaling is on, unless reported in rpm
    wire signed [31:0] vel_s   = vel_raw;
    wire signed [49:0] vel_p   = vel_s * $signed({1'b0, upr_q});
    wire               vel_sc  = scale_on & ~ctrl_q[`EPS_CTRL_RPM];        // R5
    wire        [31:0] vel_mag = vel_sc ? vel_p[47:16] : vel_raw;          // R3 R5
    always @(posedge aclk) begin
        if (!aresetn) begin
            vel_q <= 32'h0;
        end else begin
            vel_q <= ccw ? 32'h0 - vel_mag : vel_mag; // R1
        end
    end

    // axi read path; one outstanding read, data registered
    reg [31:0] rd_mux;
    reg        rd_bad;
    always @* begin
        rd_bad = 1'b0;
        case ({s_axi_araddr[7:2], 2'b00})
            `EPS_OFF_CTRL:   rd_mux = {28'h0, ctrl_q};
            `EPS_OFF_UPR:    rd_mux = {15'h0, upr_q};
            `EPS_OFF_RANGE:  rd_mux = range_q;
            `EPS_OFF_PRESET: rd_mux = preset_q;
            `EPS_OFF_OFFSET: rd_mux = offset_q;
            `EPS_OFF_POS:    rd_mux = pos_q;
            `EPS_OFF_VEL:    rd_mux = vel_q;
            `EPS_OFF_STATUS: rd_mux = {29'h0, pend_q, scale_on, valid_q};
            default: begin
                rd_mux = 32'h0;
                rd_bad = 1'b1;
            end
        endcase
    end

    assign s_axi_arready = ~rvalid_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `EPS_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_bad ? `EPS_RESP_SLVERR : `EPS_RESP_OKAY;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // outputs
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
    assign position     = pos_q;
    assign position_upd = upd_q;
    assign velocity     = vel_q;
endmodule

// ### dv/eps_top_asserts.sv
`include "eps_defs.vh"

// bus and position checks on eps_top, seen from its ports only
module eps_chk (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // write channels
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_bvalid,
    input wire [1:0]  s_axi_bresp,
    // read channels
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    // reported position
    input wire [31:0] position,
    input wire        position_upd
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // a write whose address and data are taken on the same edge
    wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire refused = s_axi_bvalid && s_axi_bresp == `EPS_RESP_SLVERR;

    a_upd_single: assert property (position_upd |=> !position_upd [*8])
        else $error("position update pulse repeated too soon");
    a_pos_on_upd: assert property ($changed(position) |-> position_upd)
        else $error("position moved without an update pulse");
    a_upd_due: assert property (position_upd |-> ##[1:1000] position_upd)
        else $error("position updates stalled");
    a_range_low: assert property (wr_both && s_axi_awaddr == `EPS_OFF_RANGE
        && s_axi_wdata < 32'h2 |-> ##[1:3] refused) else $error("short range accepted");
    a_upr_zero: assert property (wr_both && s_axi_awaddr == `EPS_OFF_UPR
        && s_axi_wdata == 32'h0 |-> ##[1:3] refused) else $error("zero units accepted");
    a_pos_ro: assert property (wr_both && s_axi_awaddr == `EPS_OFF_POS
        |-> ##[1:3] refused) else $error("position write accepted");
    a_rd_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
        |=> s_axi_rresp == `EPS_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");

    c_upd: cover property (position_upd);
    c_refused: cover property (refused);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind eps_top eps_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .position(position),
    .position_upd(position_upd)
);

// ### dv/eps_ctl_model.sv
`include "eps_defs.vh"

// network controller side: a register bus master with a few procedures
module eps_ctl_model (
    // clock
    input wire          aclk,
    // write channels
    output logic        awvalid,
    output logic [7:0]  awaddr,
    input wire          awready,
    output logic        wvalid,
    output logic [31:0] wdata,
    output logic [3:0]  wstrb,
    input wire          wready,
    input wire          bvalid,
    output logic        bready,
    input wire [1:0]    bresp,
    // read channels
    output logic        arvalid,
    output logic [7:0]  araddr,
    input wire          arready,
    input wire          rvalid,
    output logic        rready,
    input wire [31:0]   rdata,
    input wire [1:0]    rresp
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr} = 16'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
    end

    // one write; released lines show the inverse so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic [1:0] left;
        left = 2'b11;
        @(posedge aclk);
        {awvalid, wvalid, bready} <= 3'b111;
        awaddr <= a;
        wdata  <= d;
        while (left != 2'b00) begin
            @(posedge aclk);
            if (left[1] && awready) begin
                left[1] = 1'b0;
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (left[0] && wready) begin
                left[0] = 1'b0;
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    // one read, response held until sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {arvalid, rready} <= 2'b11;
        araddr <= a;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr  <= ~a;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // flip direction but keep the reading: save, flip, write back as preset
    task automatic flip_keep(input logic [31:0] ctrl, output logic [1:0] r);
        logic [31:0] p;
        logic [1:0]  r0;
        rd(`EPS_OFF_POS, p, r0);
        wr(`EPS_OFF_CTRL, ctrl, r0);
        wr(`EPS_OFF_PRESET, p, r);
    endtask
endmodule

// ### dv/encoder_position_scaling_test.sv
`include "eps_defs.vh"

module encoder_position_scaling_test;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset, sensor inputs and bus wires
    logic        aclk      = 1'b0;
    logic        aresetn   = 1'b0;
    logic [29:0] raw_count = 30'h0;
    logic [31:0] vel_raw   = 32'h0;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, position_upd;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, position, velocity;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          n_errors    = 0;
    int          check_count = 0;
    localparam logic [1:0] OK = `EPS_RESP_OKAY;
    localparam logic [1:0] SE = `EPS_RESP_SLVERR;

    always #10 aclk = ~aclk;

    eps_top dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .raw_count(raw_count), .vel_raw(vel_raw), .position(position),
        .position_upd(position_upd), .velocity(velocity)
    );
    eps_ctl_model ctl (
        .aclk(aclk), .awvalid(awvalid), .awaddr(awaddr), .awready(awready),
        .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .wready(wready), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .araddr(araddr),
        .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        ctl.wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        ctl.rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, er});
    endtask
    // let a sensor change clear its synchroniser, then two fresh pulses
    task automatic settle();
        repeat (2) begin
            repeat (3) @(posedge aclk);
            for (int i = 0; i < 300 && !position_upd; i++) @(posedge aclk);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reset values and refused places
    task automatic t_reset();
        rdc(`EPS_OFF_CTRL, 32'h4, OK);
        rdc(`EPS_OFF_UPR, 32'h10000, OK);
        rdc(`EPS_OFF_RANGE, 32'h40000000, OK);
        rdc(8'h20, 32'h0, SE);
        wrc(`EPS_OFF_POS, 32'h5, SE);
        $display("test reset done");
    endtask
    // native counts, reversal, reversal with kept position
    task automatic t_dir();
        logic [1:0] r;
        @(posedge aclk);
        raw_count <= 30'd100000;
        vel_raw   <= 32'h10000;
        settle();
        chk(position, 32'd100000);
        chk(velocity, 32'h10000);
        wrc(`EPS_OFF_CTRL, 32'h5, OK);
        settle();
        chk(position, 32'd1073641824);
        chk(velocity, 32'hffff0000);
        ctl.flip_keep(32'h4, r);
        settle();
        chk(position, 32'd1073641824);
        rdc(`EPS_OFF_OFFSET, 32'd1073541824, OK);
        $display("test direction done");
    endtask
    // scaling, offset clearing, early wrap, preset bounds
    task automatic t_scale();
        wrc(`EPS_OFF_UPR, 32'd360, OK);
        rdc(`EPS_OFF_OFFSET, 32'h0, OK);
        wrc(`EPS_OFF_OFFSET, 32'h7, OK);
        wrc(`EPS_OFF_RANGE, 32'd64800, OK);
        rdc(`EPS_OFF_OFFSET, 32'h0, OK);
        wrc(`EPS_OFF_CTRL, 32'h6, OK);
        settle();
        chk(position, 32'd549);
        chk(velocity, 32'd360);
        wrc(`EPS_OFF_CTRL, 32'he, OK);
        repeat (3) @(posedge aclk);
        chk(velocity, 32'h10000);
        wrc(`EPS_OFF_RANGE, 32'd500, OK);
        settle();
        chk(position, 32'd49);
        wrc(`EPS_OFF_PRESET, 32'd500, SE);
        wrc(`EPS_OFF_PRESET, 32'd499, OK);
        settle();
        chk(position, 32'd499);
        $display("test scale done");
    endtask
    // refused settings, then extended functions off
    task automatic t_limits();
        wrc(`EPS_OFF_RANGE, 32'h1, SE);
        wrc(`EPS_OFF_RANGE, 32'h40000001, SE);
        rdc(`EPS_OFF_RANGE, 32'd500, OK);
        wrc(`EPS_OFF_UPR, 32'h0, SE);
        wrc(`EPS_OFF_UPR, 32'h10001, SE);
        wrc(`EPS_OFF_UPR, 32'h1, OK);
        wrc(`EPS_OFF_CTRL, 32'h2, OK);
        settle();
        chk(position, 32'd100000);
        chk(velocity, 32'h10000);
        $display("test limits done");
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_dir();
        t_scale();
        t_limits();
        close_out();
    end
    // watchdog, well beyond the tests' length
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        close_out();
    end
endmodule
